/* File: inc/sck_pkg.sv */
package sck_pkg;

    // ****************************************************************
    // register map of the plain register port
    // ****************************************************************
    localparam logic [3:0] ADDR_CORE_CLOCK_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_FAST_OSC_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_MODE_STATUS = 4'h2;

    // core_clock_control fields
    localparam int SYSCLK_SEL_LSB = 5;
    localparam int HS_KEEP_BIT = 1;
    localparam int LS_KEEP_BIT = 0;
    localparam logic [2:0] SYSCLK_SEL_RST = 3'h1;
    localparam logic [2:0] SYSCLK_SEL_SUB = 3'h7;

    // fast_osc_control fields
    localparam int HS_FREQ_LSB = 2;
    localparam int HS_STABLE_BIT = 1;
    localparam int HS_EN_BIT = 0;
    localparam logic [1:0] HS_FREQ_RST = 2'h0;
    localparam logic HS_EN_RST = 1'b1;

    // ****************************************************************
    // oscillator frequencies and timing
    // ****************************************************************
    localparam int HS_FREQ_12_KHZ = 12000;
    localparam int HS_FREQ_16_KHZ = 16000;
    localparam int HS_FREQ_20_KHZ = 20000;
    localparam int LS_FREQ_HZ = 32000;
    localparam int CLK_SYS_HZ = 40000000;
    // low speed tick: clk_sys cycles per lowrc period, rounded down
    localparam int LS_DIV_CYC = CLK_SYS_HZ / LS_FREQ_HZ;
    localparam int LS_CNT_W = 11;
    // hs oscillator settle time in us, and its count in clk_sys cycles (per-us factor rounded down)
    localparam int HS_SETTLE_US = 10;
    localparam int HS_SETTLE_CYC = (HS_SETTLE_US * (CLK_SYS_HZ / 1000000));
    localparam int SETTLE_W = 9;
    localparam int DIV_W = 6;

    // frequency selection code
    typedef enum logic [1:0] {
        SCK_F12 = 2'b00,
        SCK_F16 = 2'b01,
        SCK_F20 = 2'b10,
        SCK_F12B = 2'b11
    } sck_freq_t;

    // operating modes
    typedef enum logic [2:0] {
        SCK_FAST = 3'b000,
        SCK_SLOW = 3'b001,
        SCK_DEEP_STOP = 3'b010,
        SCK_OFF_LOW = 3'b011,
        SCK_OFF_BOTH = 3'b100,
        SCK_OFF_HIGH = 3'b101
    } sck_mode_t;

    // clock enables handed to the rest of the chip
    typedef struct packed {
        logic core;
        logic hs;
        logic sub;
        logic lowrc;
    } sck_clk_t;

endpackage : sck_pkg

/* File: rtl/sck_clock_ctrl.sv */
// Functional notes
// - high speed clock from 12/16/20 MHz RC
// - low speed clock from 32kHz RC
// - hs_freq_sel picks 12, 16 or 20 MHz
// - sysclk_sel picks core clock source
// - codes 000-110: hs divided, all clocks run
// - code 111: core on sub_clk
// - hs_osc_en keeps hs running in slow
// - oscillators also feed watchdog and time base
// - halt, both keep bits 0: deep_stop
// - deep_stop lowrc runs only with watchdog
// - halt, ls keep only: cpu_off_low
// - halt, both keep bits: cpu_off_both
// - halt, hs keep only: cpu_off_high
// - sysclk_sel decode, resets to 001
// - hs_freq_sel decode, resets to 00
// - hs_stable_flag clears then sets when stable
module sck_clock_ctrl
    import sck_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic halt_instr,
    input wire logic wake_req,
    input wire logic wdt_en,
    output sck_clk_t clk_en,
    output logic [1:0] hs_freq_out,
    output logic cpu_run,
    output sck_mode_t mode
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] wake_sync;
    logic [1:0] wdt_sync;

    // wake comes from another logic block off this clock; two flops
    // trade two cycles of wake latency for a clean level
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wake_sync <= 2'h0;
        end else begin
            wake_sync <= {wake_sync[0], wake_req};
        end
    end

    // watchdog enable crosses the same way; only bit 1 feeds logic
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdt_sync <= 2'h0;
        end else begin
            wdt_sync <= {wdt_sync[0], wdt_en};
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [2:0] sysclk_sel;
    logic hs_keep_on_halt;
    logic ls_keep_on_halt;
    logic [1:0] hs_freq_sel;
    logic hs_osc_en;
    logic hs_stable_flag;
    logic [1:0] hs_freq_active;
    logic [SETTLE_W-1:0] settle_cnt;
    logic settling;

    // core clock control writes; reserved bits are not stored
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sysclk_sel <= SYSCLK_SEL_RST;
            hs_keep_on_halt <= 1'b0;
            ls_keep_on_halt <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_CORE_CLOCK_CONTROL) begin
            sysclk_sel <= reg_wdata[SYSCLK_SEL_LSB +: 3];
            hs_keep_on_halt <= reg_wdata[HS_KEEP_BIT];
            ls_keep_on_halt <= reg_wdata[LS_KEEP_BIT];
        end
    end

    // fast oscillator control writes; the stable flag bit is read only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hs_freq_sel <= HS_FREQ_RST;
            hs_osc_en <= HS_EN_RST;
        end else if (reg_wr && reg_addr == ADDR_FAST_OSC_CONTROL) begin
            hs_freq_sel <= reg_wdata[HS_FREQ_LSB +: 2];
            hs_osc_en <= reg_wdata[HS_EN_BIT];
        end
    end

    // read data stands in the cycle after the strobe only, and is zero
    // otherwise so that a wired-or read bus can sit behind this port
    // layout: core control {sel, 000, keep hs, keep ls}, osc {0000, freq, flag, en}
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CORE_CLOCK_CONTROL: reg_rdata <= {sysclk_sel, 3'h0, hs_keep_on_halt, ls_keep_on_halt};
                ADDR_FAST_OSC_CONTROL: reg_rdata <= {4'h0, hs_freq_sel, hs_stable_flag, hs_osc_en};
                ADDR_MODE_STATUS: reg_rdata <= {5'h00, mode};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // high speed oscillator run and stability
    // ****************************************************************
    logic hs_run;
    logic freq_change;
    logic hs_start;

    // a frequency write while stable forces a fresh settle
    assign freq_change = hs_stable_flag && (hs_freq_sel != hs_freq_active);

    // restart the settle count on any fresh start, or on a frequency change while stable
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hs_start <= 1'b0;
        end else begin
            hs_start <= hs_run;
        end
    end

    // a stopped oscillator loses stability; a restart clears the flag first
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hs_stable_flag <= 1'b0;
            settling <= 1'b1;
            settle_cnt <= '0;
        end else if (!hs_run || freq_change || (hs_run && !hs_start)) begin
            hs_stable_flag <= 1'b0;
            settling <= hs_run;
            settle_cnt <= '0;
        end else if (settling) begin
            if (settle_cnt == SETTLE_W'(HS_SETTLE_CYC - 1)) begin
                hs_stable_flag <= 1'b1;
                settling <= 1'b0;
            end
            settle_cnt <= settle_cnt + SETTLE_W'(1);
        end
    end

    // the new frequency takes effect only at the edge that raises the flag;
    // a restart in that same cycle wins and keeps the old code active
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hs_freq_active <= HS_FREQ_RST;
        end else if (hs_run && hs_start && settling && settle_cnt == SETTLE_W'(HS_SETTLE_CYC - 1)) begin
            hs_freq_active <= hs_freq_sel;
        end
    end

    // ****************************************************************
    // operating mode machine
    // ****************************************************************
    sck_mode_t next_mode;

    always_comb begin
        next_mode = mode;
        case (mode)
            SCK_FAST, SCK_SLOW: begin
                if (halt_instr) begin
                    case ({hs_keep_on_halt, ls_keep_on_halt})
                        2'b00: next_mode = SCK_DEEP_STOP;
                        2'b01: next_mode = SCK_OFF_LOW;
                        2'b11: next_mode = SCK_OFF_BOTH;
                        default: next_mode = SCK_OFF_HIGH;
                    endcase
                end else if (sysclk_sel == SYSCLK_SEL_SUB) begin
                    next_mode = SCK_SLOW;
                end else if (hs_stable_flag) begin
                    next_mode = SCK_FAST;
                end
            end
            SCK_DEEP_STOP, SCK_OFF_LOW, SCK_OFF_BOTH, SCK_OFF_HIGH: begin
                // resume waits for hs stability when the core needs hs_clk
                if (wake_sync[1] && (sysclk_sel == SYSCLK_SEL_SUB || hs_stable_flag)) begin
                    next_mode = (sysclk_sel == SYSCLK_SEL_SUB) ? SCK_SLOW : SCK_FAST;
                end
            end
            default: next_mode = SCK_FAST;
        endcase
    end

    // mode register; reset lands in fast so the core starts once hs settles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode <= SCK_FAST;
        end else begin
            mode <= next_mode;
        end
    end

    // hs oscillator demand in each mode; waking needs hs if core uses it
    // hs_osc_en is the master switch: with it clear hs stays off in every
    // mode, so software must keep it set while the core runs from hs
    always_comb begin
        case (mode)
            SCK_FAST: hs_run = hs_osc_en;
            SCK_SLOW: hs_run = hs_osc_en;
            SCK_OFF_BOTH, SCK_OFF_HIGH: hs_run = hs_osc_en;
            default: hs_run = wake_sync[1] && sysclk_sel != SYSCLK_SEL_SUB && hs_osc_en;
        endcase
    end

    // ****************************************************************
    // clock dividers and enables
    // ****************************************************************
    logic [DIV_W-1:0] hs_div_cnt;
    logic [LS_CNT_W-1:0] ls_cnt;
    logic ls_tick;
    logic div_tick;

    // low speed tick stands in for the 32kHz oscillator edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ls_cnt <= '0;
        end else if (ls_cnt == LS_CNT_W'(LS_DIV_CYC - 1)) begin
            ls_cnt <= '0;
        end else begin
            ls_cnt <= ls_cnt + LS_CNT_W'(1);
        end
    end
    assign ls_tick = (ls_cnt == '0);

    // free running divider of hs, cleared to zero while hs is not stable
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hs_div_cnt <= '0;
        end else if (hs_stable_flag) begin
            hs_div_cnt <= hs_div_cnt + DIV_W'(1);
        end else begin
            hs_div_cnt <= '0;
        end
    end

    // divide by 2^sel: a tick whenever the low sel bits are all zero
    always_comb begin
        div_tick = 1'b1;
        for (int i = 0; i < DIV_W; i++) begin
            if (i < int'(sysclk_sel) && hs_div_cnt[i]) begin
                div_tick = 1'b0;
            end
        end
    end

    // ****************************************************************
    // output registers
    // ****************************************************************

    // active frequency code, updated once the oscillator has settled
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hs_freq_out <= HS_FREQ_RST;
        end else begin
            hs_freq_out <= hs_freq_active;
        end
    end

    // cpu runs only in the two run modes; lags mode by one cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cpu_run <= 1'b0;
        end else begin
            cpu_run <= (mode == SCK_FAST) || (mode == SCK_SLOW);
        end
    end

    // enables for core, peripheral and watchdog clocks; the core is gated by
    // holding its enable low, so a cut clock never yields a short pulse
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clk_en <= '0;
        end else begin
            clk_en.hs <= hs_stable_flag;
            clk_en.sub <= ls_tick && mode != SCK_DEEP_STOP && mode != SCK_OFF_HIGH;
            clk_en.lowrc <= ls_tick && (mode != SCK_DEEP_STOP || wdt_sync[1]);
            case (mode)
                SCK_FAST: clk_en.core <= hs_stable_flag && div_tick;
                SCK_SLOW: clk_en.core <= ls_tick;
                SCK_OFF_BOTH: clk_en.core <= (sysclk_sel == SYSCLK_SEL_SUB) ? ls_tick : (hs_stable_flag && div_tick);
                SCK_OFF_LOW: clk_en.core <= (sysclk_sel == SYSCLK_SEL_SUB) && ls_tick;
                SCK_OFF_HIGH: clk_en.core <= (sysclk_sel != SYSCLK_SEL_SUB) && hs_stable_flag && div_tick;
                default: clk_en.core <= 1'b0;
            endcase
        end
    end

endmodule : sck_clock_ctrl

/* File: dv/sck_clock_ctrl_properties.sv */
module sck_clock_ctrl_properties
    import sck_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic halt_instr,
    input wire logic wake_req,
    input wire logic wdt_en,
    input wire sck_clk_t clk_en,
    input wire logic [1:0] hs_freq_out,
    input wire logic cpu_run,
    input wire sck_mode_t mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ccc;
    logic take;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // shadow of the core control byte, the halt decode needs its keep bits
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ccc <= 8'h20;
        end else if (reg_wr && reg_addr == ADDR_CORE_CLOCK_CONTROL) begin
            ccc <= reg_wdata;
        end
    end
    // a halt only counts while the cpu is in a run mode
    assign take = halt_instr && (mode == SCK_FAST || mode == SCK_SLOW);
    AST_HALT_DEEP: assert property (take && ccc[1:0] == 2'h0 |=> mode == SCK_DEEP_STOP)
        else $error("halt missed deep stop");
    AST_HALT_LOW: assert property (take && ccc[1:0] == 2'h1 |=> mode == SCK_OFF_LOW)
        else $error("halt missed off low");
    AST_HALT_HIGH: assert property (take && ccc[1:0] == 2'h2 |=> mode == SCK_OFF_HIGH)
        else $error("halt missed off high");
    AST_HALT_BOTH: assert property (take && ccc[1:0] == 2'h3 |=> mode == SCK_OFF_BOTH)
        else $error("halt missed off both");
    AST_CPU_STOP: assert property (mode > SCK_SLOW |=> !cpu_run)
        else $error("cpu runs in off mode");
    AST_DEEP_WDT: assert property ((mode == SCK_DEEP_STOP && !wdt_en) [*4] |-> !clk_en.lowrc)
        else $error("lowrc runs without watchdog");
    AST_DEEP_CLK: assert property (mode == SCK_DEEP_STOP [*3] |-> !clk_en.core && !clk_en.sub)
        else $error("clock runs in deep stop");
    AST_LOW_HS: assert property (mode == SCK_OFF_LOW [*3] |-> !clk_en.hs && ($past(ccc[7:5]) == 3'h7 || !clk_en.core))
        else $error("hs or core runs in off low");
    AST_HIGH_SUB: assert property (mode == SCK_OFF_HIGH [*3] |-> !clk_en.sub && ($past(ccc[7:5]) != 3'h7 || !clk_en.core))
        else $error("sub or core runs in off high");
    AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_FREQ_STABLE: assert property ($changed(hs_freq_out) |-> clk_en.hs && !$past(clk_en.hs))
        else $error("frequency code changed without a settle");
endmodule : sck_clock_ctrl_properties

/* File: dv/sck_clk_sink.sv */
module sck_clk_sink
    import sck_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire sck_clk_t clk_en,
    output logic [15:0] core_cnt,
    output logic [15:0] sub_cnt,
    output logic [15:0] lowrc_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // cpu, peripherals and watchdog/time base each step once per enable
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            core_cnt <= 16'h0000;
            sub_cnt <= 16'h0000;
            lowrc_cnt <= 16'h0000;
        end else begin
            core_cnt <= core_cnt + {15'h0000, clk_en.core};
            sub_cnt <= sub_cnt + {15'h0000, clk_en.sub};
            lowrc_cnt <= lowrc_cnt + {15'h0000, clk_en.lowrc};
        end
    end
endmodule : sck_clk_sink

/* File: dv/tb.sv */
module tb;
    import sck_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, nrst, reg_wr, reg_rd, halt_instr, wake_req, wdt_en, cpu_run;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [1:0] hs_freq_out;
    logic [15:0] core_cnt, sub_cnt, lowrc_cnt, c, s, l;
    sck_clk_t clk_en;
    sck_mode_t mode;
    sck_mode_t halt_mode [4] = '{SCK_DEEP_STOP, SCK_OFF_LOW, SCK_OFF_HIGH, SCK_OFF_BOTH};
    int err_count = 0;
    int num_checks = 0;
    sck_clock_ctrl u_sck_clock_ctrl (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .halt_instr(halt_instr), .wake_req(wake_req), .wdt_en(wdt_en), .clk_en(clk_en),
        .hs_freq_out(hs_freq_out), .cpu_run(cpu_run), .mode(mode));
    sck_clk_sink u_sck_clk_sink (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
        .core_cnt(core_cnt), .sub_cnt(sub_cnt), .lowrc_cnt(lowrc_cnt));
    task conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    // bus master: strobes one cycle long, changed just after the edge
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task hang();
        err_count++;
        $display("mismatch wait expected done seen timeout");
        conclude();
    endtask : hang
    // polls the stable flag; a dead oscillator must not stall the run
    task wait_stable();
        logic [7:0] v;
        for (int i = 0; i < 700; i++) begin
            rd(ADDR_FAST_OSC_CONTROL, v);
            if (v[HS_STABLE_BIT] === 1'b1) return;
        end
        hang();
    endtask : wait_stable
    // pulses seen by the far side over a window of n cycles
    task win(input int n);
        logic [15:0] c0, s0, l0;
        c0 = core_cnt;
        s0 = sub_cnt;
        l0 = lowrc_cnt;
        cyc(n);
        c = core_cnt - c0;
        s = sub_cnt - s0;
        l = lowrc_cnt - l0;
    endtask : win
    task halt();
        @(posedge clk_sys);
        halt_instr <= 1'b1;
        @(posedge clk_sys);
        halt_instr <= 1'b0;
        cyc(3);
    endtask : halt
    // ***************************
    // clock and stimulus
    // ***************************
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        #2500000;
        hang();
    end
    initial begin
        {nrst, reg_wr, reg_rd, halt_instr, wake_req, wdt_en, reg_addr, reg_wdata} = '0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(ADDR_CORE_CLOCK_CONTROL, q);
        chk("ccc", 16'h0020, {8'h00, q});
        rd(ADDR_FAST_OSC_CONTROL, q);
        chk("foc", 16'h0001, {8'h00, q});
        rd(4'h3, q);
        chk("unmapped", 16'h0000, {8'h00, q});
        wait_stable();
        for (int f = 2; f >= 0; f--) begin
            wr(ADDR_FAST_OSC_CONTROL, {4'h0, f[1:0], 2'h1});
            cyc(4);
            wait_stable();
            chk("freq", 16'(f), {14'h0000, hs_freq_out});
        end
        $display("test reset and frequency done");
        for (int d = 0; d < 7; d++) begin
            wr(ADDR_CORE_CLOCK_CONTROL, {d[2:0], 5'h00});
            cyc(200);
            win(512);
            chk("core fast", 16'(512 >> d), c);
        end
        $display("test divider done");
        wr(ADDR_CORE_CLOCK_CONTROL, 8'he0);
        cyc(2000);
        win(2 * LS_DIV_CYC);
        chk("core slow", 16'h0002, c);
        chk("sub slow", 16'h0002, s);
        chk("hs slow", 16'h0001, {15'h0000, clk_en.hs});
        wr(ADDR_FAST_OSC_CONTROL, 8'h00);
        cyc(10);
        chk("hs off", 16'h0000, {15'h0000, clk_en.hs});
        wr(ADDR_FAST_OSC_CONTROL, 8'h01);
        wait_stable();
        $display("test slow done");
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CORE_CLOCK_CONTROL, {(k == 2) ? 3'h7 : 3'h0, 3'h0, k[1:0]});
            cyc(2000);
            halt();
            chk("halt mode", 16'(halt_mode[k]), 16'(mode));
            if (k == 0) begin
                win(2 * LS_DIV_CYC);
                chk("lowrc no wdt", 16'h0000, l);
                @(posedge clk_sys);
                wdt_en <= 1'b1;
                cyc(4);
                win(2 * LS_DIV_CYC);
                chk("lowrc wdt", 16'h0002, l);
                @(posedge clk_sys);
                wdt_en <= 1'b0;
            end
            if (k == 3) begin
                win(2 * LS_DIV_CYC);
                chk("sub both", 16'h0002, s);
                chk("hs both", 16'h0001, {15'h0000, clk_en.hs});
            end
            halt();
            chk("second halt", 16'(halt_mode[k]), 16'(mode));
            @(posedge clk_sys);
            wake_req <= 1'b1;
            for (int i = 0; i < 1000 && cpu_run !== 1'b1; i++) cyc(1);
            if (cpu_run !== 1'b1) hang();
            chk("wake mode", (k == 2) ? 16'(SCK_SLOW) : 16'(SCK_FAST), 16'(mode));
            @(posedge clk_sys);
            wake_req <= 1'b0;
        end
        $display("test halt and wake done");
        conclude();
    end
endmodule : tb
bind sck_clock_ctrl sck_clock_ctrl_properties u_props (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .halt_instr(halt_instr), .wake_req(wake_req), .wdt_en(wdt_en),
    .clk_en(clk_en), .hs_freq_out(hs_freq_out), .cpu_run(cpu_run), .mode(mode));
